// >>> verilog/irq_seq_pkg.sv
// Constants, register map and types shared by the interrupt sequencer.
package irq_seq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_ADDR       = 8'hc8;
  localparam logic [7:0]  STATUS_ADDR    = 8'h00;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [7:0]  CFG_USED_MASK  = 8'h70;
  localparam logic [3:0]  FULL_STROBE    = 4'hf;
  localparam int          SRC1_MODE_BIT  = 6;
  localparam int          SRC2_POL_BIT   = 5;
  localparam int          GEN_BIT        = 4;

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] VEC_NMI        = 12'hffc;
  localparam logic [11:0] VEC_SRC1       = 12'hff6;
  localparam logic [11:0] VEC_SRC2       = 12'hff4;
  localparam logic [11:0] VEC_SRC3       = 12'hff2;
  localparam logic [11:0] VEC_SRC4       = 12'hff0;

  // ----------------------------------------------------------------
  // Flag sets and core modes
  // ----------------------------------------------------------------
  localparam logic [1:0]  FLAGS_MAIN     = 2'h0;
  localparam logic [1:0]  FLAGS_IRQ      = 2'h1;
  localparam logic [1:0]  FLAGS_NMI      = 2'h2;

  localparam int          STAB_CYCLES_DEF = 256;

  typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_STOP, PWR_STAB} power_state_type;

endpackage : irq_seq_pkg

// >>> verilog/edge_latch.sv
// Single request latch set by a chosen edge of an event line.
`timescale 1ns/1ps
module edge_latch (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic line,
  input  wire logic rising,
  input  wire logic arm,
  input  wire logic clr,
  output logic      pend
);

  logic line_d_r;
  logic pend_r;
  wire  edge_seen = arm & (rising ? (line & ~line_d_r) : (~line & line_d_r));

  // ----------------------------------------------------------------
  // Latch: a new edge wins over a clear in the same cycle.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_d_r <= 1'b1;
      pend_r   <= 1'b0;
    end else begin
      line_d_r <= line;
      pend_r   <= edge_seen | (pend_r & ~clr);
    end
  end

  assign pend = pend_r;

endmodule : edge_latch

// >>> verilog/stab_counter.sv
// Oscillator stabilisation counter used on wake-up from stop.
`timescale 1ns/1ps
module stab_counter #(
  parameter int CYCLES = 256
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r;
  logic          done_r;

  // ----------------------------------------------------------------
  // Count down from the start pulse and flag expiry for one cycle.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == CW'(1));
      if (start) begin
        cnt_r <= CW'(CYCLES);
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end

  assign done = done_r;

endmodule : stab_counter

// >>> verilog/irq_sequencer.sv
// Interrupt entry, return and low-power sequencer with an APB register port.
//
// Operation
// - Entry swaps carry/zero flags to irq or nmi set.
// - Entry pushes current PC onto return stack.
// - Maskable routine blocks maskable lines; NMI preempts.
// - Entry clears source latch and loads vector in the same cycle.
// - Return restores previous flag set, pops PC.
// - Maskable request during config clear load skips flag swap.
// - Config register write-only, no partial writes.
// - Reset clears config register to zero.
// - Bit 6 selects level or edge for source 1.
// - Bit 5 selects edge polarity of source 2.
// - Bit 4 enables maskable interrupts globally.
// - NMI serviced without enable, but wakes only with enable.
// - Timer overflow and conversion done share vector 4.
// - Reload timer three enabled events drive vector 3.
// - Serial end of transmission requests vector 2.
// - Ports A, B request vector 1, C vector 2.
// - Wait halts fetch, oscillator keeps running.
// - Wake from wait has no stabilisation delay.
// - Reset during wait runs normal reset.
// - Stop needs watchdog off; external interrupt wakes.
// - Wake from stop waits out stabilisation delay.
// - Wake from main runs waking routine first.
// - Polarity bit set means rising, cleared falling.
// - Source 1 edge mode triggers on falling edge.
// - Wait or stop refused while request pending.
// - Active watchdog turns stop into wait.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module irq_sequencer
  import irq_seq_pkg::*;
#(
  parameter int STAB_CYCLES = STAB_CYCLES_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        instr_end,
  input  wire logic [11:0] cur_pc,
  input  wire logic        exec_irq_return_instr,
  input  wire logic        exec_wait,
  input  wire logic        exec_stop,
  input  wire logic        cfg_clear_busy,
  input  wire logic        watchdog_active,
  input  wire logic        nmi_pin_n,
  input  wire logic [7:0]  port_a_pin,
  input  wire logic [7:0]  port_a_irq_cfg,
  input  wire logic [7:0]  port_b_pin,
  input  wire logic [7:0]  port_b_irq_cfg,
  input  wire logic [7:0]  port_c_pin,
  input  wire logic [7:0]  port_c_irq_cfg,
  input  wire logic        serial_running,
  input  wire logic        serial_done_irq_en,
  input  wire logic        timer_zero_flag,
  input  wire logic        timer_irq_en,
  input  wire logic        conversion_done_flag,
  input  wire logic        adc_irq_en,
  input  wire logic        reload_overflow_flag,
  input  wire logic        reload_overflow_irq_en,
  input  wire logic        compare_match_flag,
  input  wire logic        compare_irq_en,
  input  wire logic        reload_timer_edge_flag,
  input  wire logic        edge_irq_en,
  output logic             irq_take,
  output logic             stack_push,
  output logic [11:0]      stack_push_data,
  output logic             stack_pop,
  output logic             pc_load,
  output logic [11:0]      pc_load_value,
  output logic [1:0]       flag_set_sel,
  output logic [1:0]       core_mode,
  output logic             fetch_halt,
  output logic             osc_stop
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]      cfg_r;
  logic            pready_r;
  logic [31:0]     prdata_r;
  logic            pslverr_r;
  power_state_type pwr_r;
  power_state_type pwr_nxt;
  logic [1:0]      mode_r;
  logic [1:0]      mode_nxt;
  logic [1:0]      prev_mode_r;
  logic [1:0]      flag_r;
  logic [1:0]      flag_nxt;
  logic [1:0]      prev_flag_r;
  logic            take_r;
  logic            push_r;
  logic [11:0]     push_data_r;
  logic            pop_r;
  logic            load_r;
  logic [11:0]     load_value_r;
  logic            stab_done;
  logic            nmi_pend;
  logic            src1_latch;
  logic            src2_latch;
  logic            serial_run_d_r;
  logic            serial_done_r;
  logic            fetch_halt_r;
  logic            osc_stop_r;

  // ----------------------------------------------------------------
  // Event routing onto the four maskable sources
  // ----------------------------------------------------------------
  function automatic logic port_line(input logic [7:0] pin, input logic [7:0] cfg);
    port_line = &(pin | ~cfg);
  endfunction : port_line

  wire gen         = cfg_r[GEN_BIT];
  wire src1_level  = cfg_r[SRC1_MODE_BIT];
  wire src2_rising = cfg_r[SRC2_POL_BIT];
  wire src1_line   = port_line(port_a_pin, port_a_irq_cfg)
                   & port_line(port_b_pin, port_b_irq_cfg);
  wire src2_line   = port_line(port_c_pin, port_c_irq_cfg);
  wire src3_req    = (reload_overflow_flag & reload_overflow_irq_en)
                   | (compare_match_flag & compare_irq_en)
                   | (reload_timer_edge_flag & edge_irq_en);
  wire src4_req    = (timer_zero_flag & timer_irq_en)
                   | (conversion_done_flag & adc_irq_en);
  wire src1_req    = src1_level ? ~src1_line : src1_latch;
  wire src2_req    = src2_latch | serial_done_r;

  // ----------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------
  wire in_normal   = (mode_r == FLAGS_MAIN);
  wire mask_any    = src1_req | src2_req | src3_req | src4_req;
  wire mask_ok     = gen & in_normal & mask_any;
  wire nmi_ok      = nmi_pend & (mode_r != FLAGS_NMI);
  wire pend_en     = nmi_pend | (gen & mask_any);
  wire ext_any     = nmi_pend | src1_req | src2_latch;
  wire wake_wait   = (pwr_r == PWR_WAIT) & gen & pend_en;
  wire wake_stop   = (pwr_r == PWR_STOP) & gen & ext_any;
  wire run_point   = (pwr_r == PWR_RUN) & instr_end;
  wire resume      = wake_wait | ((pwr_r == PWR_STAB) & stab_done);
  wire take_point  = run_point | resume;
  wire take_nmi    = take_point & nmi_ok;
  wire take_mask   = take_point & ~nmi_ok & mask_ok;
  wire take_any    = take_nmi | take_mask;
  wire sel1        = src1_req;
  wire sel2        = ~src1_req & src2_req;
  wire sel3        = ~src1_req & ~src2_req & src3_req;
  wire [11:0] vec  = take_nmi ? VEC_NMI  :
                     sel1     ? VEC_SRC1 :
                     sel2     ? VEC_SRC2 :
                     sel3     ? VEC_SRC3 : VEC_SRC4;
  wire clr_nmi     = take_nmi;
  wire clr_src1    = take_mask & sel1;
  wire clr_src2    = take_mask & sel2;
  wire skip_swap   = take_mask & cfg_clear_busy;
  wire irq_return_instr_now    = exec_irq_return_instr & (pwr_r == PWR_RUN) & ~in_normal;
  wire low_ok      = (pwr_r == PWR_RUN) & ~pend_en;
  wire go_stop     = low_ok & exec_stop & ~watchdog_active;
  wire go_wait     = low_ok & (exec_wait | (exec_stop & watchdog_active));
  wire start_stab  = wake_stop;

  // ----------------------------------------------------------------
  // Request latches and stabilisation counter
  // ----------------------------------------------------------------
  edge_latch u_nmi_latch (
    .pclk    (pclk),
    .presetn (presetn),
    .line    (nmi_pin_n),
    .rising  (1'b0),
    .arm     (1'b1),
    .clr     (clr_nmi),
    .pend    (nmi_pend)
  );

  edge_latch u_src1_latch (
    .pclk    (pclk),
    .presetn (presetn),
    .line    (src1_line),
    .rising  (1'b0),
    .arm     (~src1_level),
    .clr     (clr_src1 | src1_level),
    .pend    (src1_latch)
  );

  edge_latch u_src2_latch (
    .pclk    (pclk),
    .presetn (presetn),
    .line    (src2_line),
    .rising  (src2_rising),
    .arm     (1'b1),
    .clr     (clr_src2),
    .pend    (src2_latch)
  );

  stab_counter #(
    .CYCLES (STAB_CYCLES)
  ) u_stab (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start_stab),
    .done    (stab_done)
  );

  // ----------------------------------------------------------------
  // Power state and mode next values
  // ----------------------------------------------------------------
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_RUN: begin
        if (go_stop) begin
          pwr_nxt = PWR_STOP;
        end else if (go_wait) begin
          pwr_nxt = PWR_WAIT;
        end
      end
      PWR_WAIT: begin
        if (wake_wait) begin
          pwr_nxt = PWR_RUN;
        end
      end
      PWR_STOP: begin
        if (wake_stop) begin
          pwr_nxt = PWR_STAB;
        end
      end
      PWR_STAB: begin
        if (stab_done) begin
          pwr_nxt = PWR_RUN;
        end
      end
      default: begin
        pwr_nxt = PWR_RUN;
      end
    endcase
  end

  always_comb begin
    mode_nxt = mode_r;
    flag_nxt = flag_r;
    if (take_nmi) begin
      mode_nxt = FLAGS_NMI;
      flag_nxt = FLAGS_NMI;
    end else if (take_mask) begin
      mode_nxt = FLAGS_IRQ;
      flag_nxt = skip_swap ? flag_r : FLAGS_IRQ;
    end else if (irq_return_instr_now) begin
      mode_nxt = prev_mode_r;
      flag_nxt = prev_flag_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r        <= PWR_RUN;
      mode_r       <= FLAGS_MAIN;
      flag_r       <= FLAGS_MAIN;
      prev_mode_r  <= FLAGS_MAIN;
      prev_flag_r  <= FLAGS_MAIN;
      take_r       <= 1'b0;
      push_r       <= 1'b0;
      push_data_r  <= 12'h000;
      pop_r        <= 1'b0;
      load_r       <= 1'b0;
      load_value_r <= 12'h000;
      fetch_halt_r <= 1'b0;
      osc_stop_r   <= 1'b0;
    end else begin
      pwr_r        <= pwr_nxt;
      mode_r       <= mode_nxt;
      flag_r       <= flag_nxt;
      if (take_any | irq_return_instr_now) begin
        prev_mode_r <= take_any ? mode_r : FLAGS_MAIN;
        prev_flag_r <= take_any ? flag_r : FLAGS_MAIN;
      end
      take_r       <= take_any;
      push_r       <= take_any;
      push_data_r  <= take_any ? cur_pc : push_data_r;
      pop_r        <= irq_return_instr_now;
      load_r       <= take_any;
      load_value_r <= take_any ? vec : load_value_r;
      fetch_halt_r <= (pwr_nxt != PWR_RUN);
      osc_stop_r   <= (pwr_nxt == PWR_STOP);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_run_d_r <= 1'b0;
      serial_done_r  <= 1'b0;
    end else begin
      serial_run_d_r <= serial_running;
      serial_done_r  <= (serial_done_irq_en & serial_run_d_r & ~serial_running)
                      | (serial_done_r & ~(take_mask & sel2));
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire        access   = psel & penable & ~pready_r;
  wire        hit_cfg  = (paddr == CFG_ADDR);
  wire        hit_stat = (paddr == STATUS_ADDR);
  wire        bad_cfg  = hit_cfg & (~pwrite | (pstrb != FULL_STROBE));
  wire        bad_stat = hit_stat & pwrite;
  wire        err      = bad_cfg | bad_stat | ~(hit_cfg | hit_stat);
  wire        cfg_we   = psel & penable & pready_r & hit_cfg & ~bad_cfg;
  wire [31:0] status   = {16'h0000, nmi_pend, src1_req, src2_req, src3_req, src4_req,
                          3'b000, pwr_r, flag_r, mode_r, 1'b0, gen};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r     <= CFG_RESET;
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= access;
      pslverr_r <= access & err;
      prdata_r  <= (access & hit_stat & ~pwrite) ? status : 32'h0000_0000;
      if (cfg_we) begin
        cfg_r <= pwdata[7:0] & CFG_USED_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready          = pready_r;
  assign prdata          = prdata_r;
  assign pslverr         = pslverr_r;
  assign irq_take        = take_r;
  assign stack_push      = push_r;
  assign stack_push_data = push_data_r;
  assign stack_pop       = pop_r;
  assign pc_load         = load_r;
  assign pc_load_value   = load_value_r;
  assign flag_set_sel    = flag_r;
  assign core_mode       = mode_r;
  assign fetch_halt      = fetch_halt_r;
  assign osc_stop        = osc_stop_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_FLAG_SWAP: assert property (take_mask & ~cfg_clear_busy |=> flag_r == FLAGS_IRQ)
    else $error("flag set not swapped on entry");
  AST_PUSH_PC: assert property (take_any |=> push_r && push_data_r == $past(cur_pc))
    else $error("pc not pushed on entry");
  AST_MASK_BLOCK: assert property (mode_r != FLAGS_MAIN |-> !take_mask)
    else $error("maskable entry while in routine");
  AST_VECTOR: assert property (take_nmi |=> load_r && load_value_r == VEC_NMI)
    else $error("nmi vector not loaded");
  AST_RETURN: assert property (irq_return_instr_now |=> pop_r && flag_r == $past(prev_flag_r))
    else $error("flag set not restored on return");
  AST_QUIRK: assert property (take_mask & cfg_clear_busy & in_normal |=>
      mode_r == FLAGS_IRQ && flag_r == FLAGS_MAIN)
    else $error("flag swap during config clear");
  AST_NO_WAKE: assert property (pwr_r == PWR_WAIT && !gen |=> pwr_r == PWR_WAIT)
    else $error("woke with global enable low");
  AST_STOP_AS_WAIT: assert property (exec_stop & watchdog_active & low_ok |=>
      pwr_r == PWR_WAIT)
    else $error("stop not turned into wait");
  AST_REFUSE: assert property (pwr_r == PWR_RUN && pend_en |=> pwr_r == PWR_RUN)
    else $error("low power entered with request pending");
  AST_STAB: assert property (wake_stop |=> (pwr_r == PWR_STAB) [*2])
    else $error("stop exit skipped stabilisation");

endmodule : irq_sequencer

// >>> tb/core_model.sv
// Behavioural processor core: instruction end pulses, program counter, return stack.
`timescale 1ns/1ps
module core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fetch_halt,
  input  wire logic        stack_push,
  input  wire logic [11:0] stack_push_data,
  input  wire logic        stack_pop,
  input  wire logic        pc_load,
  input  wire logic [11:0] pc_load_value,
  output logic             instr_end,
  output logic [11:0]      cur_pc
);
  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  logic [11:0] stack_r [0:7];
  logic [2:0]  depth_r;
  logic [1:0]  phase_r;

  assign instr_end = (phase_r == 2'h3) && !fetch_halt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'h0;
      depth_r <= 3'h0;
      cur_pc  <= 12'h000;
    end else begin
      if (!fetch_halt) begin
        phase_r <= phase_r + 2'h1;
      end
      if (stack_push) begin
        stack_r[depth_r] <= stack_push_data;
        depth_r          <= depth_r + 3'h1;
      end
      if (pc_load) begin
        cur_pc <= pc_load_value;
      end else if (stack_pop) begin
        cur_pc  <= stack_r[depth_r - 3'h1];
        depth_r <= depth_r - 3'h1;
      end else if (instr_end) begin
        cur_pc <= cur_pc + 12'h001;
      end
    end
  end
endmodule : core_model

// >>> tb/irq_sequencer_tb.sv
// Self-checking testbench of the interrupt sequencer.
`timescale 1ns/1ps
module irq_sequencer_tb;
  import irq_seq_pkg::*;
  localparam int STAB = 4;
  typedef struct { int k; logic [11:0] vec; } row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exec_irq_return_instr, exec_wait;
  logic exec_stop, cfg_clear_busy, watchdog_active, nmi_pin_n, instr_end, irq_take;
  logic stack_push, stack_pop, pc_load, fetch_halt, osc_stop;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [11:0] cur_pc, stack_push_data, pc_load_value;
  logic [1:0]  flag_set_sel, core_mode;
  logic [8:0]  src;
  logic        er;
  int          fails, check_count, n;
  row_type     rows [9] = '{'{0, VEC_SRC4}, '{1, VEC_SRC4}, '{2, VEC_SRC3}, '{3, VEC_SRC3},
                            '{4, VEC_SRC3}, '{5, VEC_SRC1}, '{6, VEC_SRC1}, '{7, VEC_SRC2},
                            '{8, VEC_SRC2}};

  irq_sequencer #(.STAB_CYCLES(STAB)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .instr_end(instr_end), .cur_pc(cur_pc), .exec_irq_return_instr(exec_irq_return_instr),
    .exec_wait(exec_wait), .exec_stop(exec_stop), .cfg_clear_busy(cfg_clear_busy),
    .watchdog_active(watchdog_active), .nmi_pin_n(nmi_pin_n),
    .port_a_pin({7'h7f, ~src[5]}), .port_a_irq_cfg({7'h00, src[5]}),
    .port_b_pin({7'h7f, ~src[6]}), .port_b_irq_cfg({7'h00, src[6]}),
    .port_c_pin({7'h7f, ~src[7]}), .port_c_irq_cfg({7'h00, src[7]}),
    .serial_running(~src[8]), .serial_done_irq_en(1'b1),
    .timer_zero_flag(src[0]), .timer_irq_en(src[0]),
    .conversion_done_flag(src[1]), .adc_irq_en(src[1]),
    .reload_overflow_flag(src[2]), .reload_overflow_irq_en(src[2]),
    .compare_match_flag(src[3]), .compare_irq_en(src[3]),
    .reload_timer_edge_flag(src[4]), .edge_irq_en(src[4]),
    .irq_take(irq_take), .stack_push(stack_push), .stack_push_data(stack_push_data),
    .stack_pop(stack_pop), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .flag_set_sel(flag_set_sel), .core_mode(core_mode), .fetch_halt(fetch_halt),
    .osc_stop(osc_stop));

  core_model i_core (
    .pclk(pclk), .presetn(presetn), .fetch_halt(fetch_halt), .stack_push(stack_push),
    .stack_push_data(stack_push_data), .stack_pop(stack_pop), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .instr_end(instr_end), .cur_pc(cur_pc));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    for (i = 0; i < 50 && pready !== 1'b1; i++) begin
      @(negedge pclk);
    end
    if (pready !== 1'b1) begin
      fails++;
      final_report();
    end else begin
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic take(input logic [11:0] vec, input logic [1:0] fs);
    for (n = 1; n <= 60 && irq_take !== 1'b1; n++) begin
      @(negedge pclk);
    end
    if (irq_take !== 1'b1) begin
      fails++;
      final_report();
    end else begin
      check(pc_load_value, vec);
      check(stack_push, 1'b1);
      check(flag_set_sel, fs);
      @(posedge pclk);
    end
  endtask : take

  task automatic no_take();
    repeat (20) begin
      @(negedge pclk);
      check(irq_take, 1'b0);
    end
    @(posedge pclk);
  endtask : no_take

  task automatic irq_return_instr(input logic [1:0] fs);
    exec_irq_return_instr <= 1'b1;
    @(posedge pclk);
    exec_irq_return_instr <= 1'b0;
    @(negedge pclk);
    check(stack_pop, 1'b1);
    check(flag_set_sel, fs);
    @(posedge pclk);
  endtask : irq_return_instr

  task automatic sleep(input logic stp);
    exec_wait <= !stp;
    exec_stop <= stp;
    @(posedge pclk);
    exec_wait <= 1'b0;
    exec_stop <= 1'b0;
    @(negedge pclk);
    check(fetch_halt, 1'b1);
    @(posedge pclk);
  endtask : sleep

  task automatic final_report();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, exec_irq_return_instr, exec_wait, exec_stop} = 6'h00;
    {cfg_clear_busy, watchdog_active, src, paddr, pwdata, pstrb} = '0;
    nmi_pin_n = 1'b1;
    presetn   = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, STATUS_ADDR, 32'h0, 4'h0);
    check(rd[0], 1'b0);
    apb(1'b0, CFG_ADDR, 32'h0, 4'h0);
    check(er, 1'b1);
    apb(1'b1, CFG_ADDR, 32'h10, 4'h1);
    check(er, 1'b1);
    src[0] <= 1'b1;
    no_take();
    nmi_pin_n <= 1'b0;
    take(VEC_NMI, FLAGS_NMI);
    nmi_pin_n <= 1'b1;
    irq_return_instr(FLAGS_MAIN);
    src[0] <= 1'b0;
    apb(1'b1, CFG_ADDR, 32'h10, FULL_STROBE);
    check(er, 1'b0);
    foreach (rows[i]) begin
      src[rows[i].k] <= 1'b1;
      take(rows[i].vec, FLAGS_IRQ);
      src[rows[i].k] <= 1'b0;
      irq_return_instr(FLAGS_MAIN);
    end
    src <= 9'h020;
    @(posedge pclk);
    src <= 9'h021;
    take(VEC_SRC1, FLAGS_IRQ);
    no_take();
    nmi_pin_n <= 1'b0;
    take(VEC_NMI, FLAGS_NMI);
    nmi_pin_n <= 1'b1;
    src <= 9'h000;
    irq_return_instr(FLAGS_IRQ);
    irq_return_instr(FLAGS_MAIN);
    cfg_clear_busy <= 1'b1;
    src[2] <= 1'b1;
    take(VEC_SRC3, FLAGS_MAIN);
    check(core_mode, FLAGS_IRQ);
    {cfg_clear_busy, src[2]} <= 2'b00;
    irq_return_instr(FLAGS_MAIN);
    sleep(1'b0);
    src[1] <= 1'b1;
    take(VEC_SRC4, FLAGS_IRQ);
    check(n <= 3, 1'b1);
    src[1] <= 1'b0;
    irq_return_instr(FLAGS_MAIN);
    sleep(1'b1);
    check(osc_stop, 1'b1);
    src[7] <= 1'b1;
    take(VEC_SRC2, FLAGS_IRQ);
    check(n > STAB, 1'b1);
    src[7] <= 1'b0;
    irq_return_instr(FLAGS_MAIN);
    watchdog_active <= 1'b1;
    sleep(1'b1);
    check(osc_stop, 1'b0);
    src[3] <= 1'b1;
    take(VEC_SRC3, FLAGS_IRQ);
    src[3] <= 1'b0;
    irq_return_instr(FLAGS_MAIN);
    sleep(1'b0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(fetch_halt, 1'b0);
    check(core_mode, FLAGS_MAIN);
    apb(1'b0, STATUS_ADDR, 32'h0, 4'h0);
    check(rd[0], 1'b0);
    final_report();
  end
endmodule : irq_sequencer_tb
